// >>> core/optf_pkg.sv
// shared constants and types for the output port link training machine
package optf_pkg;

   // ----------------------------------------------------------------
   // pattern burst
   // ----------------------------------------------------------------
   localparam int PTTN_BURST = 256;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_LAST = 8'(PTTN_BURST - 1);

   // ----------------------------------------------------------------
   // symbol kinds offered to the transmitter
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SYM_NONE    = 2'h0,
      SYM_TRN_REQ = 2'h1,
      SYM_PTTN    = 2'h2,
      SYM_IDLE    = 2'h3
   } optf_sym_t;

   // ----------------------------------------------------------------
   // training states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      ST_RESET     = 8'h01,
      ST_TRN_REQ   = 8'h02,
      ST_PTTN      = 8'h04,
      ST_IDLE      = 8'h08,
      ST_OK        = 8'h10,
      ST_LIVE_PTTN = 8'h20,
      ST_LIVE_IDLE = 8'h40,
      ST_LIVE_REQ  = 8'h80
   } optf_state_t;

   localparam optf_state_t ST_AFTER_RESET = ST_RESET;

endpackage

// >>> core/optf_cnt_if.sv
// carrier between the training machine and its pattern counter
`timescale 1ns/1ps
interface optf_cnt_if;
   logic clear;
   logic step;
   logic last;
   modport ctl (output clear, output step, input last);
   modport cnt (input clear, input step, output last);
endinterface

// >>> core/optf_pttn_cnt.sv
// pattern iteration counter for the training bursts
`timescale 1ns/1ps
module optf_pttn_cnt
   import optf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   optf_cnt_if.cnt cif
);

   typedef struct packed {
      logic [CNT_W-1:0] count;
   } optf_cnt_regs_t;

   optf_cnt_regs_t r;
   optf_cnt_regs_t next_r;

   // ----------------------------------------------------------------
   // counting
   // ----------------------------------------------------------------
   always_comb begin
      next_r = r;
      if (cif.clear) begin
         next_r.count = CNT_RESET;
      end else if (cif.step) begin
         next_r.count = r.count + CNT_ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r.count <= CNT_RESET;
      end else begin
         r <= next_r;
      end
   end

   // last pattern of the burst is the one in flight while count is at its top
   assign cif.last = (r.count == CNT_LAST);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   cnt_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      cif.clear |=> r.count == CNT_RESET)
      else $error("pattern counter not cleared on burst entry");
   cnt_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      cif.step && !cif.clear |=> r.count == $past(r.count) + CNT_ONE)
      else $error("pattern counter did not advance");

endmodule // optf_pttn_cnt

// >>> core/optf_train.sv
// output port link training state machine
`timescale 1ns/1ps
module optf_train
   import optf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start_trn,
   input wire logic in_ok,
   input wire logic in_wait_pttn,
   input wire logic idle_req,
   input wire logic restart_req,
   input wire logic recal_req,
   input wire logic rx_trn_req_pkt,
   input wire logic rx_trn_req_pttn,
   input wire logic pkt_active,
   input wire logic sym_taken,
   output logic [1:0] tx_sym,
   output logic tx_sym_valid,
   output logic pkt_enable,
   output logic err_report_en,
   output logic [7:0] train_state
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      optf_state_t st;
      optf_sym_t sym;
      logic sym_valid;
      logic pkt_en;
      logic err_en;
   } optf_regs_t;

   optf_regs_t r;
   optf_regs_t next_r;
   logic sent;
   logic in_burst;
   logic live;

   optf_cnt_if cif ();

   optf_pttn_cnt u_cnt (
      .clk   (clk),
      .rst_n (rst_n),
      .cif   (cif)
   );

   // a symbol counts as sent only when the transmitter takes what we offer
   assign sent = r.sym_valid & sym_taken;
   assign in_burst = (r.st == ST_PTTN) || (r.st == ST_LIVE_PTTN);
   assign live = (r.st == ST_LIVE_PTTN) || (r.st == ST_LIVE_IDLE) || (r.st == ST_LIVE_REQ);

   // ----------------------------------------------------------------
   // counter control
   // ----------------------------------------------------------------
   assign cif.step = sent & in_burst;
   assign cif.clear = ((next_r.st == ST_PTTN) && (r.st != ST_PTTN)) ||
                      ((next_r.st == ST_LIVE_PTTN) && (r.st != ST_LIVE_PTTN));

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_r = r;
      case (r.st)
         ST_RESET: begin
            if (start_trn) begin
               next_r.st = ST_TRN_REQ;
            end
         end
         ST_TRN_REQ: begin
            if (sent) begin
               next_r.st = ST_PTTN;
            end
         end
         ST_PTTN: begin
            if (sent && cif.last) begin
               // idle_req comes from the input side once it is calibrated
               next_r.st = idle_req ? ST_IDLE : ST_TRN_REQ;
            end
         end
         ST_IDLE: begin
            if (sent) begin
               if (in_ok) begin
                  next_r.st = ST_OK;
               end else if (in_wait_pttn) begin
                  next_r.st = ST_TRN_REQ;
               end else begin
                  next_r.st = ST_PTTN;
               end
            end
         end
         ST_OK: begin
            // lost sampling outranks any maintenance request
            if (restart_req) begin
               next_r.st = ST_TRN_REQ;
            end else if (rx_trn_req_pttn) begin
               next_r.st = ST_PTTN;
            end else if (rx_trn_req_pkt) begin
               next_r.st = ST_LIVE_PTTN;
            end else if (recal_req) begin
               next_r.st = ST_LIVE_REQ;
            end
         end
         ST_LIVE_PTTN: begin
            if (restart_req) begin
               next_r.st = ST_TRN_REQ;
            end else if (sent && cif.last) begin
               next_r.st = ST_LIVE_IDLE;
            end
         end
         ST_LIVE_IDLE: begin
            if (restart_req) begin
               next_r.st = ST_TRN_REQ;
            end else if (sent) begin
               next_r.st = ST_OK;
            end
         end
         ST_LIVE_REQ: begin
            if (restart_req) begin
               next_r.st = ST_TRN_REQ;
            end else if (sent && !pkt_active) begin
               next_r.st = ST_OK;
            end
         end
         default: begin
            next_r.st = ST_RESET;
         end
      endcase

      // outputs follow the next state so that they leave flip-flops
      case (next_r.st)
         ST_TRN_REQ, ST_LIVE_REQ: begin
            next_r.sym = SYM_TRN_REQ;
         end
         ST_PTTN, ST_LIVE_PTTN: begin
            next_r.sym = SYM_PTTN;
         end
         ST_IDLE, ST_LIVE_IDLE: begin
            next_r.sym = SYM_IDLE;
         end
         default: begin
            next_r.sym = SYM_NONE;
         end
      endcase
      // a request symbol cannot sit inside a packet, so hold it back
      if (next_r.st == ST_LIVE_REQ) begin
         next_r.sym_valid = !pkt_active;
      end else begin
         next_r.sym_valid = (next_r.sym != SYM_NONE);
      end
      next_r.err_en = (next_r.st == ST_OK) || (next_r.st == ST_LIVE_PTTN) ||
                      (next_r.st == ST_LIVE_IDLE) || (next_r.st == ST_LIVE_REQ);
      next_r.pkt_en = in_ok && next_r.err_en;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r.st <= ST_AFTER_RESET;
         r.sym <= SYM_NONE;
         r.sym_valid <= 1'b0;
         r.pkt_en <= 1'b0;
         r.err_en <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign tx_sym = r.sym;
   assign tx_sym_valid = r.sym_valid;
   assign pkt_enable = r.pkt_en;
   assign err_report_en = r.err_en;
   assign train_state = r.st;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   pkt_gate_a: assert property (
      pkt_enable |-> $past(in_ok) && (r.st == ST_OK || live))
      else $error("packets enabled outside operational states");
   reset_hold_a: assert property (
      r.st == ST_RESET && !start_trn |=> r.st == ST_RESET && !tx_sym_valid)
      else $error("left reset state without start");
   req_entry_a: assert property (
      r.st == ST_RESET && start_trn |=> tx_sym == SYM_TRN_REQ && tx_sym_valid)
      else $error("no training request after start");
   burst_entry_a: assert property (
      r.st == ST_TRN_REQ && sent |=> r.st == ST_PTTN ##0 tx_sym == SYM_PTTN)
      else $error("request not followed by pattern burst");
   burst_hold_a: assert property (
      r.st == ST_PTTN && !(sent && cif.last) && !restart_req |=> r.st == ST_PTTN)
      else $error("pattern burst ended early");
   burst_idle_a: assert property (
      r.st == ST_PTTN && sent && cif.last && idle_req |=> r.st == ST_IDLE ##0 tx_sym == SYM_IDLE)
      else $error("no idle after calibrated burst");
   burst_loop_a: assert property (
      r.st == ST_PTTN && sent && cif.last && !idle_req |=> r.st == ST_TRN_REQ)
      else $error("burst loop did not repeat request");
   idle_exit_a: assert property (
      r.st == ST_IDLE && sent && in_ok |=> r.st == ST_OK ##0 err_report_en)
      else $error("idle did not lead to operational");
   idle_retry_a: assert property (
      r.st == ST_IDLE && sent && !in_ok && !in_wait_pttn |=> r.st == ST_PTTN)
      else $error("idle did not fall back to burst");
   idle_restart_a: assert property (
      r.st == ST_IDLE && sent && !in_ok && in_wait_pttn |=> r.st == ST_TRN_REQ)
      else $error("idle did not restart training");
   ok_stay_a: assert property (
      r.st == ST_OK && !restart_req && !rx_trn_req_pttn && !rx_trn_req_pkt && !recal_req
      |=> r.st == ST_OK && err_report_en && !tx_sym_valid)
      else $error("operational state left without cause");
   live_burst_a: assert property (
      r.st == ST_OK && !restart_req && !rx_trn_req_pttn && rx_trn_req_pkt
      |=> r.st == ST_LIVE_PTTN && tx_sym == SYM_PTTN)
      else $error("maintenance request not served");
   live_req_a: assert property (
      r.st == ST_OK && !restart_req && !rx_trn_req_pttn && !rx_trn_req_pkt && recal_req
      |=> r.st == ST_LIVE_REQ)
      else $error("recalibration request ignored");
   restart_a: assert property (
      r.st == ST_OK && restart_req |=> r.st == ST_TRN_REQ ##0 !pkt_enable)
      else $error("restart request ignored");
   resync_a: assert property (
      r.st == ST_OK && !restart_req && rx_trn_req_pttn |=> r.st == ST_PTTN ##0 !pkt_enable)
      else $error("far end loss of sync ignored");
   live_idle_a: assert property (
      r.st == ST_LIVE_PTTN && sent && cif.last && !restart_req
      |=> tx_sym == SYM_IDLE && err_report_en)
      else $error("live burst not closed by idle");
   live_wait_a: assert property (
      r.st == ST_LIVE_REQ && pkt_active && !restart_req |=> !tx_sym_valid && err_report_en)
      else $error("request offered inside a packet");
   live_done_a: assert property (
      r.st == ST_LIVE_REQ && sent && !pkt_active && !restart_req |=> r.st == ST_OK)
      else $error("live request did not return to operational");

   // ----------------------------------------------------------------
   // symbol offers per state
   // ----------------------------------------------------------------
   req_sym_a: assert property (
      r.st == ST_TRN_REQ |-> tx_sym == SYM_TRN_REQ && tx_sym_valid)
      else $error("training request not offered");
   req_wait_a: assert property (
      r.st == ST_TRN_REQ && !sent |=> r.st == ST_TRN_REQ)
      else $error("training request dropped before it was sent");
   pttn_sym_a: assert property (
      in_burst |-> tx_sym == SYM_PTTN && tx_sym_valid)
      else $error("pattern not offered during burst");
   burst_start_a: assert property (
      in_burst && !$past(in_burst) |-> !cif.last)
      else $error("burst entered with a stale pattern count");
   idle_sym_a: assert property (
      r.st == ST_IDLE || r.st == ST_LIVE_IDLE |-> tx_sym == SYM_IDLE && tx_sym_valid)
      else $error("idle not offered after burst");
   idle_wait_a: assert property (
      r.st == ST_IDLE && !sent |=> r.st == ST_IDLE)
      else $error("idle state left before the idle was sent");
   idle_once_a: assert property (
      r.st == ST_IDLE && sent |=> r.st != ST_IDLE)
      else $error("more than one idle sent");
   reset_out_a: assert property (
      r.st == ST_RESET |-> !tx_sym_valid && !pkt_enable && !err_report_en)
      else $error("outputs active in reset state");
   ok_quiet_a: assert property (
      r.st == ST_OK |-> !tx_sym_valid && tx_sym == SYM_NONE)
      else $error("training symbol offered while operational");
   ok_entry_a: assert property (
      r.st == ST_OK && $past(r.st) != ST_OK |-> $past(r.st) == ST_IDLE ||
      $past(r.st) == ST_LIVE_IDLE || $past(r.st) == ST_LIVE_REQ)
      else $error("operational entered without a sent idle or request");

   // ----------------------------------------------------------------
   // packet and error reporting gates
   // ----------------------------------------------------------------
   // both gates leave flip-flops fed from the next state, so they track r.st with no lag
   train_gate_a: assert property (
      !(r.st == ST_OK || live) |-> !pkt_enable && !err_report_en)
      else $error("packets or errors enabled while training");
   err_on_a: assert property (
      r.st == ST_OK || live |-> err_report_en)
      else $error("error reporting off while operational");
   pkt_on_a: assert property (
      in_ok |=> pkt_enable == err_report_en)
      else $error("packets not enabled with input side operational");
   pkt_off_a: assert property (
      !in_ok |=> !pkt_enable)
      else $error("packets enabled without input side operational");

   // ----------------------------------------------------------------
   // live maintenance paths
   // ----------------------------------------------------------------
   // a restart outranks every live step, since sampling is already lost
   live_hold_a: assert property (
      r.st == ST_LIVE_PTTN && !(sent && cif.last) && !restart_req |=> r.st == ST_LIVE_PTTN)
      else $error("live burst ended early");
   live_close_a: assert property (
      r.st == ST_LIVE_IDLE && sent && !restart_req |=> r.st == ST_OK)
      else $error("live idle did not return to operational");
   live_restart_a: assert property (
      live && restart_req |=> r.st == ST_TRN_REQ)
      else $error("restart request ignored during live training");
   live_req_sym_a: assert property (
      r.st == ST_LIVE_REQ |-> tx_sym == SYM_TRN_REQ)
      else $error("live request holds the wrong symbol");
   live_resume_a: assert property (
      r.st == ST_LIVE_REQ && !pkt_active && !restart_req && !sent |=> tx_sym_valid)
      else $error("live request not offered after packet end");
   live_req_hold_a: assert property (
      r.st == ST_LIVE_REQ && !(sent && !pkt_active) && !restart_req |=> r.st == ST_LIVE_REQ)
      else $error("live request left before it was sent");

   // ----------------------------------------------------------------
   // scenario coverage
   // ----------------------------------------------------------------
   reach_ok_c: cover property (r.st == ST_IDLE && sent && in_ok ##1 r.st == ST_OK);
   loop_c: cover property (r.st == ST_PTTN && sent && cif.last && !idle_req);
   live_burst_c: cover property (r.st == ST_LIVE_IDLE && sent ##1 r.st == ST_OK);
   live_req_c: cover property (r.st == ST_LIVE_REQ && sent ##1 r.st == ST_OK);
   resync_c: cover property (r.st == ST_OK && !restart_req && rx_trn_req_pttn ##1 r.st == ST_PTTN);

endmodule // optf_train

// >>> verif/optf_tx_model.sv
// transmitter model that takes offered symbols and sends packets
`timescale 1ns/1ps
module optf_tx_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tx_sym_valid,
   input wire logic stall,
   input wire logic send_pkt,
   output logic sym_taken,
   output logic pkt_active
);
   // ----------------------------------------------------------------
   // symbol take and packet flag
   // ----------------------------------------------------------------
   // a stall keeps the offer from being taken; no symbol is taken while a packet runs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sym_taken <= 1'b0;
         pkt_active <= 1'b0;
      end else begin
         sym_taken <= tx_sym_valid && !stall && !send_pkt;
         pkt_active <= send_pkt;
      end
   end
endmodule // optf_tx_model

// >>> verif/test_output_port_link_training_fsm.sv
// self-checking bench for the output port training machine
`timescale 1ns/1ps
module test_output_port_link_training_fsm;
   import optf_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, start_trn = 1'b0, in_ok = 1'b0, in_wait_pttn = 1'b0;
   logic idle_req = 1'b0, restart_req = 1'b0, recal_req = 1'b0;
   logic rx_trn_req_pkt = 1'b0, rx_trn_req_pttn = 1'b0, stall = 1'b0, send_pkt = 1'b0;
   logic pkt_active, sym_taken, tx_sym_valid, pkt_enable, err_report_en;
   logic [1:0] tx_sym;
   logic [7:0] train_state;
   integer seed = 65;
   int miscompares = 0;
   int total_checks = 0;
   int pcnt = 0;
   int last_burst = 0;
   logic [3:0] sel [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hF};
   logic [7:0] nxt [5] = '{ST_TRN_REQ, ST_PTTN, ST_LIVE_PTTN, ST_LIVE_REQ, ST_TRN_REQ};

   always #25 clk = ~clk;

   optf_train optf_train_i (.clk(clk), .rst_n(rst_n), .start_trn(start_trn), .in_ok(in_ok),
      .in_wait_pttn(in_wait_pttn), .idle_req(idle_req), .restart_req(restart_req),
      .recal_req(recal_req), .rx_trn_req_pkt(rx_trn_req_pkt),
      .rx_trn_req_pttn(rx_trn_req_pttn), .pkt_active(pkt_active), .sym_taken(sym_taken),
      .tx_sym(tx_sym), .tx_sym_valid(tx_sym_valid), .pkt_enable(pkt_enable),
      .err_report_en(err_report_en), .train_state(train_state));

   optf_tx_model optf_tx_model_i (.clk(clk), .rst_n(rst_n), .tx_sym_valid(tx_sym_valid),
      .stall(stall), .send_pkt(send_pkt), .sym_taken(sym_taken), .pkt_active(pkt_active));

   // ----------------------------------------------------------------
   // random stalls and burst length monitor
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      stall <= (($random(seed) & 3) == 0);
   end

   // counts taken patterns per burst; latched once the burst state is left
   always @(posedge clk) begin
      if (train_state !== ST_PTTN && train_state !== ST_LIVE_PTTN) begin
         if (pcnt != 0) begin
            last_burst <= pcnt;
         end
         pcnt <= 0;
      end else if (tx_sym_valid === 1'b1 && sym_taken === 1'b1 && tx_sym === SYM_PTTN) begin
         pcnt <= pcnt + 1;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // bounded wait; a stalled burst still ends well inside the limit
   task automatic wait_state(input logic [7:0] target);
      int n;
      n = 0;
      while (train_state !== target && n < 3000) begin
         @(negedge clk);
         n++;
      end
      chk("train_state", target, train_state);
      if (train_state !== target) begin
         complete_run();
      end
   endtask

   task automatic burst_chk();
      @(posedge clk);
      @(negedge clk);
      chk("burst length", 16'(PTTN_BURST), 16'(last_burst));
   endtask

   task automatic set_in(input logic [3:0] v);
      @(posedge clk);
      {idle_req, in_ok, in_wait_pttn, send_pkt} <= v;
   endtask

   // one-cycle request pulse; the effect is due right after the sampling edge
   task automatic pulse(input logic [3:0] v);
      @(posedge clk);
      {restart_req, rx_trn_req_pttn, rx_trn_req_pkt, recal_req} <= v;
      @(posedge clk);
      {restart_req, rx_trn_req_pttn, rx_trn_req_pkt, recal_req} <= 4'h0;
      @(negedge clk);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("held state", ST_RESET, train_state);
      chk("held valid", 8'h00, 8'(tx_sym_valid));
      @(posedge clk);
      start_trn <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk("start state", ST_TRN_REQ, train_state);
      chk("start symbol", 8'(SYM_TRN_REQ), 8'(tx_sym));
      chk("no packets", 8'h00, 8'(pkt_enable));
      wait_state(ST_PTTN);
      wait_state(ST_TRN_REQ);
      burst_chk();
      set_in(4'h8);
      wait_state(ST_IDLE);
      chk("idle symbol", 8'(SYM_IDLE), 8'(tx_sym));
      wait_state(ST_PTTN);
      set_in(4'hA);
      wait_state(ST_IDLE);
      wait_state(ST_TRN_REQ);
      set_in(4'hC);
      wait_state(ST_OK);
      chk("errors on", 8'h01, 8'(err_report_en));
      chk("packets on", 8'h01, 8'(pkt_enable));
      repeat (5) @(posedge clk);
      @(negedge clk);
      chk("stay ok", ST_OK, train_state);
      set_in(4'h8);
      @(posedge clk);
      @(negedge clk);
      chk("packets off", 8'h00, 8'(pkt_enable));
      set_in(4'hC);
      for (int k = 0; k < 5; k++) begin
         set_in((k == 3) ? 4'hD : 4'hC);
         pulse(sel[k]);
         chk("request state", nxt[k], train_state);
         if (k == 2 || k == 3) begin
            chk("live errors", 8'h01, 8'(err_report_en));
         end
         if (k == 3) begin
            chk("valid in packet", 8'h00, 8'(tx_sym_valid));
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk("wait packet end", ST_LIVE_REQ, train_state);
            set_in(4'hC);
         end
         if (k == 2) begin
            wait_state(ST_LIVE_IDLE);
            burst_chk();
         end
         wait_state(ST_OK);
      end
      // restart while a live request waits behind a packet
      set_in(4'hD);
      pulse(4'h1);
      chk("live held", ST_LIVE_REQ, train_state);
      pulse(4'h8);
      chk("live restart", ST_TRN_REQ, train_state);
      chk("restart packets", 8'h00, 8'(pkt_enable));
      set_in(4'hC);
      wait_state(ST_OK);
      complete_run();
   end
endmodule // test_output_port_link_training_fsm
